// File: hw/scuh_sys_ctrl.sv
// System control upper half: config access, global fields and two socket copies
`timescale 1ns/10ps
module scuh_sys_ctrl
    import scuh_pkg::*;
(
    input  wire logic        mclk,              // 50 MHz configuration clock
    input  wire logic        rst_n,             // Synchronous reset, active low
    input  wire logic        cfgWrite,          // Pulse: config write
    input  wire logic        cfgRead,           // Pulse: config read
    input  wire logic        cfgFunc,           // Function number, 0 or 1
    input  wire logic [7:0]  cfgAddr,           // Doubleword byte offset
    input  wire logic [3:0]  cfgBe,             // Byte enables
    input  wire logic [31:0] cfgWdata,          // Write data
    output logic      [31:0] cfgRdata,          // Read data, registered
    output logic             cfgRdValid,        // Pulse: read data valid
    input  wire logic        funcAIrq,          // Function 0 interrupt level
    input  wire logic        funcBIrq,          // Function 1 interrupt level
    output logic      [3:0]  slotIrq,           // Serial slots A..D, registered
    input  wire logic        switchClockIn,     // Switch clock pin input
    output logic             switchClockOut,    // Switch clock pin output
    output logic             switchClockOe,     // Switch clock pin output enable
    output logic             switchClock,       // Switch clock level in use
    input  wire logic [1:0]  socketPowerWrite,  // Pulse per socket: power written
    output logic             powerIrq2,         // Power-write interrupt on IRQ2
    output logic      [1:0]  cardStatusIrq,     // Power-write as card-status interrupt
    input  wire logic [1:0]  cardPresent,       // Card-bus card present pins
    output logic      [1:0]  spareOut,          // Spare terminal output level
    output logic      [1:0]  spareOe,           // Spare terminal output enable
    output logic      [1:0]  supplyProtectEn,   // Supply protection per socket
    input  wire logic [1:0]  cardDreq,          // Selected card DMA request pins
    output logic      [1:0]  dmaRequest,        // Gated DMA requests
    output logic      [5:0]  dmaChannel         // Channels, socket 1 in bits 5:3
);

    localparam int unsigned ROT   = SCUH_ROT_LSB - SCUH_HALF_LSB;
    localparam int unsigned MRG   = SCUH_MERGE_BIT - SCUH_HALF_LSB;
    localparam int unsigned CSEL  = SCUH_CLKSEL_BIT - SCUH_HALF_LSB;
    localparam int unsigned RTE   = SCUH_ROUTE_BIT - SCUH_HALF_LSB;
    localparam int unsigned IEN   = SCUH_IRQEN_BIT - SCUH_HALF_LSB;

    // Global fields: one copy shared by both functions
    logic [1:0]  rot_q;          // Slot rotation
    logic        merge_q;        // Merge function interrupts
    logic        clkSel_q;       // Switch clock source select
    logic        route_q;        // Power-write interrupt route
    logic        irqEn_q;        // Power-write interrupt enable

    // Synchronisers for pins
    logic        swClkMeta_q;    // First stage, read only by second
    logic        swClkSync_q;    // Second stage
    logic [1:0]  presMeta_q;     // First stage, read only by second
    logic [1:0]  presSync_q;     // Second stage
    logic [1:0]  dreqMeta_q;     // First stage, read only by second
    logic [1:0]  dreqSync_q;     // Second stage

    // Switch clock divider
    logic [7:0]  divCnt_q;       // Half-period counter
    logic        divClk_q;       // Divided clock level

    // Access decode
    logic        regHit;         // Access targets the register
    logic        wrHit;          // Write to the register
    logic [1:0]  sockWr;         // Write steered to socket copy
    logic [1:0]  upperBe;        // Byte enables of bytes 3 and 2
    logic [15:0] upperWr;        // Upper half of write data
    logic [15:0] globalRd;       // Global fields in upper-half layout
    logic [15:0] sockRd [2];     // Socket fields per function
    logic [1:0]  sockIrq;        // Per-socket active interrupt
    logic [3:0]  slotNext;       // Slot pattern before the flop

    assign regHit  = (cfgAddr == SCUH_SYSCTL_OFFSET);
    assign wrHit   = cfgWrite & regHit;
    assign upperBe = cfgBe[3:2];
    assign upperWr = cfgWdata[31:16];
    assign sockWr  = {wrHit & cfgFunc, wrHit & ~cfgFunc};

    // Global fields: function 1 writes are dropped so one copy stays coherent
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            rot_q    <= SCUH_ROT_RESET;
            merge_q  <= SCUH_UPPER_RESET[MRG];
            clkSel_q <= SCUH_UPPER_RESET[CSEL];
            route_q  <= SCUH_UPPER_RESET[RTE];
            irqEn_q  <= SCUH_UPPER_RESET[IEN];
        end else if (wrHit && !cfgFunc && upperBe[1]) begin
            rot_q    <= upperWr[ROT +: 2];
            merge_q  <= upperWr[MRG];
            clkSel_q <= upperWr[CSEL];
            route_q  <= upperWr[RTE];
            irqEn_q  <= upperWr[IEN];
        end
    end

    // Global read image; bits 28, 23 and 20 are absent and read zero
    always_comb begin
        globalRd           = '0;
        globalRd[ROT +: 2] = rot_q;
        globalRd[MRG]      = merge_q;
        globalRd[CSEL]     = clkSel_q;
        globalRd[RTE]      = route_q;
        globalRd[IEN]      = irqEn_q;
    end

    // Read port: one cycle latency, lower half and other offsets read zero
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            cfgRdata   <= 32'h0000_0000;
            cfgRdValid <= 1'b0;
        end else begin
            cfgRdValid <= cfgRead;
            if (cfgRead && regHit) begin
                cfgRdata <= {globalRd | sockRd[cfgFunc], 16'h0000};
            end else if (cfgRead) begin
                cfgRdata <= 32'h0000_0000;
            end
        end
    end

    // Pin synchronisers: two flops each before any logic looks
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            swClkMeta_q <= 1'b0;
            swClkSync_q <= 1'b0;
            presMeta_q  <= 2'b00;
            presSync_q  <= 2'b00;
            dreqMeta_q  <= 2'b00;
            dreqSync_q  <= 2'b00;
        end else begin
            swClkMeta_q <= switchClockIn;
            swClkSync_q <= swClkMeta_q;
            presMeta_q  <= cardPresent;
            presSync_q  <= presMeta_q;
            dreqMeta_q  <= cardDreq;
            dreqSync_q  <= dreqMeta_q;
        end
    end

    // Divider: free-running so the driven clock is ready the moment it is selected
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            divCnt_q <= 8'h00;
            divClk_q <= 1'b0;
        end else if (divCnt_q == SCUH_SWCLK_HALF_LAST) begin
            divCnt_q <= 8'h00;
            divClk_q <= ~divClk_q;
        end else begin
            divCnt_q <= divCnt_q + 8'h01;
        end
    end

    // Clock in use: the external pin must serve during suspend, software keeps select low then
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            switchClock <= 1'b0;
        end else begin
            switchClock <= clkSel_q ? divClk_q : swClkSync_q;
        end
    end

    assign switchClockOut = divClk_q;
    assign switchClockOe  = clkSel_q;

    // Slot mapping: function A lands on slot rot, B on the next one, or both on slot rot when merged
    function automatic logic [3:0] slot_map(input logic [1:0] rot, input logic merge,
                                            input logic a, input logic b);
        logic [3:0] base;
        base = merge ? {3'b000, a | b} : {2'b00, b, a};
        return (4'({base, base} << rot) | 4'(({base, base} << rot) >> 4));
    endfunction

    assign slotNext = slot_map(rot_q, merge_q, funcAIrq, funcBIrq);

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            slotIrq <= 4'h0;
        end else begin
            slotIrq <= slotNext;
        end
    end

    // Two socket copies of the socket-dependent fields
    for (genvar s = 0; s < 2; s++) begin : g_sock
        scuh_socket_ctrl u_sock (
            .mclk            (mclk),
            .rst_n           (rst_n),
            .wrHit           (sockWr[s]),
            .wrBe            (upperBe),
            .wrData          (upperWr),
            .powerWrite      (socketPowerWrite[s]),
            .irqEnable       (irqEn_q),
            .cardPresent     (presSync_q[s]),
            .cardDreq        (dreqSync_q[s]),
            .fieldsRd        (sockRd[s]),
            .irqActive       (sockIrq[s]),
            .spareOe         (spareOe[s]),
            .supplyProtectEn (supplyProtectEn[s]),
            .dmaRequest      (dmaRequest[s]),
            .dmaChannel      (dmaChannel[3*s +: 3])
        );
    end

    // Routing of the power-write interrupt, held as long as flag and enable stand
    assign powerIrq2     = |sockIrq & ~route_q;
    assign cardStatusIrq = sockIrq & {2{route_q}};
    assign spareOut      = 2'b00;

    a_slot_rotate: assert property (@(posedge mclk) disable iff (!rst_n)
        ##1 slotIrq == slot_map($past(rot_q), $past(merge_q), $past(funcAIrq), $past(funcBIrq)))
        else $error("slot pattern does not follow rotation");
    a_merge_tie: assert property (@(posedge mclk) disable iff (!rst_n)
        (merge_q && rot_q == 2'h0 && funcBIrq && !funcAIrq) |=> slotIrq == 4'h1)
        else $error("merged interrupt not on slot A");
    a_rsvd_zero: assert property (@(posedge mclk) disable iff (!rst_n)
        cfgRdValid |-> (cfgRdata[SCUH_RSVD28_BIT] == 1'b0 && cfgRdata[SCUH_RSVD20_BIT] == 1'b0))
        else $error("reserved bit read nonzero");
    a_clock_out: assert property (@(posedge mclk) disable iff (!rst_n)
        (switchClockOe == clkSel_q) and (clkSel_q ##1 clkSel_q |-> switchClock == $past(divClk_q)))
        else $error("switch clock source wrong");
    a_route_irq2: assert property (@(posedge mclk) disable iff (!rst_n)
        (route_q |-> !powerIrq2) and (!route_q |-> cardStatusIrq == 2'b00))
        else $error("power interrupt on wrong route");
    a_global_f1: assert property (@(posedge mclk) disable iff (!rst_n)
        (wrHit && cfgFunc) |=> $stable(rot_q) && $stable(irqEn_q))
        else $error("function 1 write changed global field");
    a_offset_hit: assert property (@(posedge mclk) disable iff (!rst_n)
        (cfgRead && !regHit) |=> cfgRdValid && cfgRdata == 32'h0000_0000)
        else $error("unmapped offset returned data");
    a_irq_enable: assert property (@(posedge mclk) disable iff (!rst_n)
        !irqEn_q |-> (!powerIrq2 && cardStatusIrq == 2'b00))
        else $error("interrupt while disabled");

    c_merge_used:  cover property (@(posedge mclk) disable iff (!rst_n) merge_q && funcBIrq);
    c_irq2_raised: cover property (@(posedge mclk) disable iff (!rst_n) powerIrq2);
    c_clk_driven:  cover property (@(posedge mclk) disable iff (!rst_n) switchClockOe && $rose(divClk_q));
    c_dma_request: cover property (@(posedge mclk) disable iff (!rst_n) |dmaRequest);

endmodule

// File: hw/scuh_pkg.sv
// Package with offsets, field positions, reset values and timing counts of the system control upper half
package scuh_pkg;

    // Configuration space location of the doubleword register
    localparam logic [7:0]  SCUH_SYSCTL_OFFSET   = 8'h80;

    // Field positions within the 32-bit doubleword
    localparam int unsigned SCUH_ROT_LSB         = 30;   // Slot rotation, two bits
    localparam int unsigned SCUH_MERGE_BIT       = 29;
    localparam int unsigned SCUH_RSVD28_BIT      = 28;
    localparam int unsigned SCUH_CLKSEL_BIT      = 27;
    localparam int unsigned SCUH_ROUTE_BIT       = 26;
    localparam int unsigned SCUH_FLAG_BIT        = 25;
    localparam int unsigned SCUH_IRQEN_BIT       = 24;
    localparam int unsigned SCUH_RSVD23_BIT      = 23;
    localparam int unsigned SCUH_SPARE_BIT       = 22;
    localparam int unsigned SCUH_PROT_BIT        = 21;
    localparam int unsigned SCUH_RSVD20_BIT      = 20;
    localparam int unsigned SCUH_DREQEN_BIT      = 19;
    localparam int unsigned SCUH_CHAN_LSB        = 16;   // DMA channel, three bits
    localparam int unsigned SCUH_HALF_LSB        = 16;   // Upper half starts here

    // Reset value of the upper half (bits 31..16)
    localparam logic [15:0] SCUH_UPPER_RESET     = 16'h0044;
    localparam logic [1:0]  SCUH_ROT_RESET       = 2'h0;
    localparam logic [2:0]  SCUH_CHAN_RESET      = 3'h4;

    // DMA channel encodings
    localparam logic [2:0]  SCUH_CHAN_PCI_MASTER = 3'h4;
    localparam logic [2:0]  SCUH_CHAN_WIDE_MIN   = 3'h5;

    // Switch clock generation from the 50 MHz clock
    localparam int unsigned SCUH_MCLK_PERIOD_NS  = 20;
    localparam int unsigned SCUH_SWCLK_HALF_NS   = 500;
    localparam int unsigned SCUH_SWCLK_HALF_CYC  = (SCUH_SWCLK_HALF_NS / SCUH_MCLK_PERIOD_NS < 1) ? 1 :
                                                   SCUH_SWCLK_HALF_NS / SCUH_MCLK_PERIOD_NS;
    localparam logic [7:0]  SCUH_SWCLK_HALF_LAST = 8'(SCUH_SWCLK_HALF_CYC - 1);

endpackage

// File: hw/scuh_socket_ctrl.sv
// Per-socket copy of the socket-dependent system control fields
`timescale 1ns/10ps
module scuh_socket_ctrl
    import scuh_pkg::*;
(
    input  wire logic        mclk,            // 50 MHz clock
    input  wire logic        rst_n,           // Synchronous reset, active low
    input  wire logic        wrHit,           // Config write to this function at the register
    input  wire logic [1:0]  wrBe,            // Byte enables of bytes 3 and 2
    input  wire logic [15:0] wrData,          // Write data, upper half
    input  wire logic        powerWrite,      // Pulse: software wrote socket power
    input  wire logic        irqEnable,       // Shared power-write interrupt enable
    input  wire logic        cardPresent,     // Synchronised card-bus card present
    input  wire logic        cardDreq,        // Synchronised DMA request of the card
    output logic      [15:0] fieldsRd,        // Socket fields in upper-half layout
    output logic             irqActive,       // Flag and enable both set
    output logic             spareOe,         // Spare terminals driven low
    output logic             supplyProtectEn, // Supply protection active
    output logic             dmaRequest,      // Gated DMA request
    output logic      [2:0]  dmaChannel       // Centralized DMA channel
);

    localparam int unsigned FLAG = SCUH_FLAG_BIT - SCUH_HALF_LSB;
    localparam int unsigned SPR  = SCUH_SPARE_BIT - SCUH_HALF_LSB;
    localparam int unsigned PROT = SCUH_PROT_BIT - SCUH_HALF_LSB;
    localparam int unsigned DREQ = SCUH_DREQEN_BIT - SCUH_HALF_LSB;
    localparam int unsigned CHAN = SCUH_CHAN_LSB - SCUH_HALF_LSB;

    logic       flag_q;      // Power-write interrupt flag
    logic       spare_q;     // Spare terminal drive
    logic       protDis_q;   // Supply protection disable
    logic       dreqEn_q;    // Card DMA request enable
    logic [2:0] chan_q;      // DMA channel
    logic       flagSet;     // Hardware set event
    logic       flagClr;     // Software write-one clear

    assign flagSet = powerWrite & irqEnable;
    assign flagClr = wrHit & wrBe[1] & wrData[FLAG];

    // Flag: set wins over a clear landing in the same cycle, so no event is lost
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            flag_q <= 1'b0;
        end else begin
            flag_q <= flagSet | (flag_q & ~flagClr);
        end
    end

    // Plain read/write socket fields, byte 2 only
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            spare_q   <= SCUH_UPPER_RESET[SPR];
            protDis_q <= SCUH_UPPER_RESET[PROT];
            dreqEn_q  <= SCUH_UPPER_RESET[DREQ];
            chan_q    <= SCUH_CHAN_RESET;
        end else if (wrHit && wrBe[0]) begin
            spare_q   <= wrData[SPR];
            protDis_q <= wrData[PROT];
            dreqEn_q  <= wrData[DREQ];
            chan_q    <= wrData[CHAN +: 3];
        end
    end

    // Outputs; reserved positions stay zero
    always_comb begin
        fieldsRd             = '0;
        fieldsRd[FLAG]       = flag_q;
        fieldsRd[SPR]        = spare_q;
        fieldsRd[PROT]       = protDis_q;
        fieldsRd[DREQ]       = dreqEn_q;
        fieldsRd[CHAN +: 3]  = chan_q;
    end

    assign irqActive       = flag_q & irqEnable;
    assign spareOe         = spare_q & cardPresent;
    assign supplyProtectEn = ~protDis_q;
    assign dmaRequest      = dreqEn_q & cardDreq;
    assign dmaChannel      = chan_q;

    a_flag_set_wins: assert property (@(posedge mclk) disable iff (!rst_n)
        flagSet |=> flag_q)
        else $error("power write with enable did not set flag");
    a_flag_clear: assert property (@(posedge mclk) disable iff (!rst_n)
        (flagClr && !flagSet) |=> !flag_q)
        else $error("write one did not clear flag");
    a_irq_follow: assert property (@(posedge mclk) disable iff (!rst_n)
        flagSet ##1 irqEnable |-> irqActive)
        else $error("interrupt not held after flag set");
    a_spare_drive: assert property (@(posedge mclk) disable iff (!rst_n)
        (wrHit && wrBe[0] && !wrData[SPR]) |=> !spareOe)
        else $error("spare terminals driven while disabled");
    a_dma_gate: assert property (@(posedge mclk) disable iff (!rst_n)
        (wrHit && wrBe[0] && !wrData[DREQ]) |=> !dmaRequest)
        else $error("DMA request passed while disabled");
    c_flag_raised: cover property (@(posedge mclk) disable iff (!rst_n) flagSet ##[1:20] flagClr);

endmodule

// File: dv/scuh_host_model.sv
// Host model issuing configuration reads and writes to both socket functions
`timescale 1ns/10ps
module scuh_host_model (
    input  wire logic        mclk,       // 50 MHz clock
    output logic             cfgWrite,   // Write strobe
    output logic             cfgRead,    // Read strobe
    output logic             cfgFunc,    // Function number
    output logic      [7:0]  cfgAddr,    // Doubleword byte offset
    output logic      [3:0]  cfgBe,      // Byte enables
    output logic      [31:0] cfgWdata,   // Write data
    input  wire logic [31:0] cfgRdata,   // Read data
    input  wire logic        cfgRdValid  // Read data valid
);
    // Idle bus at time zero
    initial begin
        cfgWrite = 1'b0;
        cfgRead  = 1'b0;
        cfgFunc  = 1'b0;
        cfgAddr  = 8'h00;
        cfgBe    = 4'h0;
        cfgWdata = 32'h0000_0000;
    end
    // One write strobe: raised at a falling edge, taken at the next rising edge
    task automatic wr(input logic f, input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
        @(negedge mclk);
        cfgFunc  = f;
        cfgAddr  = a;
        cfgBe    = be;
        cfgWdata = d;
        cfgWrite = 1'b1;
        @(negedge mclk);
        cfgWrite = 1'b0;
        cfgWdata = ~d; // Stale data scrambled so it is never trusted
    endtask
    // One read strobe; data taken while the valid pulse stands, unknown if it is missing
    task automatic rd(input logic f, input logic [7:0] a, output logic [31:0] d);
        @(negedge mclk);
        cfgFunc = f;
        cfgAddr = a;
        cfgRead = 1'b1;
        @(negedge mclk);
        cfgRead = 1'b0;
        d = (cfgRdValid === 1'b1) ? cfgRdata : 32'hxxxx_xxxx;
    endtask
endmodule

// File: dv/system_control_upper_half_bench.sv
// Self-checking bench of the system control upper half
`timescale 1ns/10ps
module system_control_upper_half_bench;
    import scuh_pkg::*;
    logic        mclk, rst_n, cfgWrite, cfgRead, cfgFunc, cfgRdValid, funcAIrq, funcBIrq; // Bus and irq
    logic [7:0]  cfgAddr;                 // Offset
    logic [3:0]  cfgBe, slotIrq;          // Byte enables, slots
    logic [31:0] cfgWdata, cfgRdata, r;   // Data
    logic        swIn, swOut, swOe, swClk, powerIrq2; // Switch clock pins, IRQ2
    logic [1:0]  pwrWr, csIrq, present, spareOut, spareOe, protEn, dreq, dmaReq; // Socket pins
    logic [5:0]  dmaChannel;              // Channels
    logic [15:0] glob, sock [2];          // Expected register contents
    logic [1:0]  flag;                    // Expected status flags
    int          miscompares, checksDone, cycles, seed, n; // Counters
    scuh_sys_ctrl uut (.mclk(mclk), .rst_n(rst_n), .cfgWrite(cfgWrite), .cfgRead(cfgRead), .cfgFunc(cfgFunc),
        .cfgAddr(cfgAddr), .cfgBe(cfgBe), .cfgWdata(cfgWdata), .cfgRdata(cfgRdata), .cfgRdValid(cfgRdValid),
        .funcAIrq(funcAIrq), .funcBIrq(funcBIrq), .slotIrq(slotIrq), .switchClockIn(swIn),
        .switchClockOut(swOut), .switchClockOe(swOe), .switchClock(swClk), .socketPowerWrite(pwrWr),
        .powerIrq2(powerIrq2), .cardStatusIrq(csIrq), .cardPresent(present), .spareOut(spareOut),
        .spareOe(spareOe), .supplyProtectEn(protEn), .cardDreq(dreq), .dmaRequest(dmaReq),
        .dmaChannel(dmaChannel));
    scuh_host_model host (.mclk(mclk), .cfgWrite(cfgWrite), .cfgRead(cfgRead), .cfgFunc(cfgFunc),
        .cfgAddr(cfgAddr), .cfgBe(cfgBe), .cfgWdata(cfgWdata), .cfgRdata(cfgRdata), .cfgRdValid(cfgRdValid));
    // Clock at 20 ns period
    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end
    // Hang guard: the whole run needs well under two thousand cycles
    always @(posedge mclk) begin
        cycles++;
        if (cycles > 5000) begin
            miscompares++;
            wrap_up();
        end
    end
    task automatic wrap_up();
        if (miscompares == 0 && checksDone > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        checksDone++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    // Expected read: shared globals, own socket fields, own flag; reserved bits zero
    function automatic logic [31:0] expRead(input logic f);
        return {(glob & 16'hED00) | (sock[f] & 16'h006F) | {6'h00, flag[f], 9'h000}, 16'h0000};
    endfunction
    // Expected slot levels for a rotation, merge bit and the two function levels
    function automatic logic [3:0] expSlot(input logic [1:0] rot, input logic m, input logic a, input logic b);
        return ({3'h0, a | (b & m)} << rot) | ({3'h0, b & ~m} << 2'(rot + 2'd1));
    endfunction
    // Pins that follow the register at once, ordered to match the got vector
    task automatic pinChk();
        chk({17'h0, spareOut, protEn, dmaChannel, spareOe, dmaReq, swOe}, {17'h0, 2'b00, ~sock[1][5], ~sock[0][5],
            sock[1][2:0],
            sock[0][2:0], sock[1][6] & present[1], sock[0][6] & present[0], sock[1][3] & dreq[1],
            sock[0][3] & dreq[0], glob[11]}, "pins");
        chk({29'h0, powerIrq2, csIrq}, {29'h0, ~glob[10] & glob[8] & |flag, {2{glob[10] & glob[8]}} & flag},
            "power irq");
    endtask
    // Bus write mirrored into the expected contents
    task automatic wrM(input logic f, input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
        logic [15:0] m;
        m = (a == SCUH_SYSCTL_OFFSET) ? {{8{be[3]}}, {8{be[2]}}} : 16'h0000;
        host.wr(f, a, be, d);
        if (f == 1'b0) glob = (glob & ~m) | (d[31:16] & m);
        sock[f] = (sock[f] & ~m) | (d[31:16] & m);
        if (m[9] && d[25]) flag[f] = 1'b0;
        pinChk();
    endtask
    // Socket power write pulse of one cycle
    task automatic pw(input logic [1:0] s);
        @(negedge mclk);
        pwrWr = s;
        @(negedge mclk);
        pwrWr = 2'b00;
        if (glob[8]) flag = flag | s;
        pinChk();
    endtask
    initial begin
        {rst_n, funcAIrq, funcBIrq, swIn, pwrWr, present, dreq} = '0;
        {miscompares, checksDone, cycles} = '0;
        seed = 32'h8fcb;
        glob = 16'h0000;
        sock[0] = SCUH_UPPER_RESET;
        sock[1] = SCUH_UPPER_RESET;
        flag = 2'b00;
        repeat (10) @(negedge mclk);
        rst_n = 1'b1;
        for (int f = 0; f < 2; f++) begin
            host.rd(f[0], SCUH_SYSCTL_OFFSET, r);
            chk(r, 32'h0044_0000, "reset value");
        end
        host.rd(1'b0, 8'h84, r);
        chk(r, 32'h0000_0000, "other offset");
        // Random writes to both functions, some to another offset
        for (int i = 0; i < 60; i++) begin
            present = 2'($random(seed));
            dreq = 2'($random(seed));
            wrM(1'($random(seed)), ($random(seed) & 3) ? SCUH_SYSCTL_OFFSET : 8'h84, 4'($random(seed)),
                32'($random(seed)) | ((i == 0) ? 32'hFFFF_0000 : 32'h0));
            for (int f = 0; f < 2; f++) begin
                host.rd(f[0], SCUH_SYSCTL_OFFSET, r);
                chk(r, expRead(f[0]), "readback");
            end
        end
        // Mid-run reset: defaults return in both functions
        rst_n = 1'b0;
        repeat (2) @(negedge mclk);
        rst_n = 1'b1;
        glob = 16'h0000;
        sock[0] = SCUH_UPPER_RESET;
        sock[1] = SCUH_UPPER_RESET;
        host.rd(1'b1, SCUH_SYSCTL_OFFSET, r);
        chk(r, 32'h0044_0000, "value after mid-run reset");
        pinChk();
        // Power-write interrupt: route, flag per socket, clear through each function
        wrM(1'b0, SCUH_SYSCTL_OFFSET, 4'b1000, 32'h0100_0000);
        pw(2'b01);
        host.rd(1'b0, SCUH_SYSCTL_OFFSET, r);
        chk(r, expRead(1'b0), "flag set");
        wrM(1'b0, SCUH_SYSCTL_OFFSET, 4'b1000, 32'h0700_0000);
        wrM(1'b0, SCUH_SYSCTL_OFFSET, 4'b1000, 32'h0500_0000);
        pw(2'b10);
        wrM(1'b1, SCUH_SYSCTL_OFFSET, 4'b1000, 32'h0200_0000);
        // Power write and write-one clear in one cycle: the set must win
        fork
            host.wr(1'b0, SCUH_SYSCTL_OFFSET, 4'b1000, 32'h0700_0000);
            pw(2'b01);
        join
        wrM(1'b0, SCUH_SYSCTL_OFFSET, 4'b1000, 32'h0000_0000);
        pw(2'b11);
        // Slot rotation and merge for every code and each input mix with at least one level high
        for (int i = 0; i < 24; i++) begin
            if (i % 3 == 0) wrM(1'b0, SCUH_SYSCTL_OFFSET, 4'b1000, {3'(i / 3), 29'h0});
            @(negedge mclk);
            {funcBIrq, funcAIrq} = 2'(i % 3 + 1);
            @(negedge mclk);
            chk({28'h0, slotIrq}, {28'h0, expSlot(glob[15:14], glob[13], funcAIrq, funcBIrq)}, "slots");
        end
        // Switch clock: divided clock driven out, then taken from the pin
        wrM(1'b0, SCUH_SYSCTL_OFFSET, 4'b1000, 32'h0800_0000);
        // Half period timed between two toggles; the divider runs free, so the first toggle is the sync point
        for (int k = 0; k < 2; k++) begin
            n = 0;
            r[0] = swOut;
            while (swOut === r[0] && n < 60) begin
                @(negedge mclk);
                n++;
            end
        end
        chk(n, SCUH_SWCLK_HALF_CYC, "divided clock half period");
        chk({31'h0, swClk}, {31'h0, ~swOut}, "clock in use one cycle behind");
        wrM(1'b0, SCUH_SYSCTL_OFFSET, 4'b1000, 32'h0000_0000);
        for (int v = 1; v >= 0; v--) begin
            swIn = v[0];
            repeat (4) @(negedge mclk);
            chk({31'h0, swClk}, {31'h0, v[0]}, "clock from pin");
        end
        wrap_up();
    end
endmodule
